// ---- core/prof_flow.v ----
// Read-back output FIFO flow control with APB register access.
`timescale 1ns/1ps
`default_nettype none
`include "prof_map.vh"

module prof_flow (
    // Clock, reset and enable.
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Commands from the command controller.
    input wire cmd_valid,
    input wire [1:0] cmd_kind,
    output wire cmd_ready,
    // Pixel processor data path.
    input wire pix_valid,
    input wire [31:0] pix_data,
    output wire pix_ready,
    // Host side status.
    output wire dma_req,
    output wire stalled,
    output wire irq
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CHECK = 4'h2;
    localparam [3:0] ST_RUN = 4'h4;
    localparam [3:0] ST_STALL = 4'h8;
    localparam integer DEPTH_INT = `PROF_DEPTH;
    localparam [9:0] DEPTH10 = DEPTH_INT[9:0];
    localparam [`PROF_CW-1:0] DEPTH_C = DEPTH_INT[`PROF_CW-1:0];

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [8:0] rem_r;
    reg [8:0] rem_nxt;
    reg arr_r;
    reg arr_nxt;
    reg [7:0] req_r;
    reg [`PROF_CW-1:0] limit_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    reg [31:0] prdata_r;
    reg pready_r;
    reg pslverr_r;
    reg cmd_ready_r;
    reg pix_ready_r;
    reg dma_req_r;
    reg stalled_r;
    reg irq_r;
    reg [31:0] rd_mux;
    reg rd_hit;

    wire [31:0] fifo_rd_data;
    wire [`PROF_CW-1:0] count;
    wire apb_setup = psel & ~penable;
    wire apb_done = psel & penable & pready_r;
    wire wr_done = apb_done & pwrite;
    wire push = pix_valid & pix_ready_r;
    wire pop = apb_done & ~pwrite & (paddr == `PROF_ADDR_DATA) & (count != {`PROF_CW{1'b0}});
    wire cmd_take = cmd_valid & cmd_ready_r;
    wire [`PROF_CW-1:0] occ_nxt = count + {{(`PROF_CW-1){1'b0}}, push}
                                  - {{(`PROF_CW-1){1'b0}}, pop};
    wire [9:0] need = {3'h0, count} + {2'h0, req_r} + 10'h001;
    wire fits = (need <= DEPTH10);
    wire resume = (need < DEPTH10);
    wire [8:0] group_len = {1'b0, req_r} + 9'h001;
    wire level = (limit_r != {`PROF_CW{1'b0}}) && (count >= limit_r);
    wire group_end = push & ~arr_r & (rem_r == 9'h001);
    wire stall_enter = (state_r == ST_CHECK) & ~cmd_take & ~fits;

    prof_out_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .wr_en(push),
        .wr_data(pix_data),
        .rd_en(pop),
        .rd_data(fifo_rd_data),
        .count(count)
    );

    // Command decode and group sequencing.
    always @* begin
        state_nxt = state_r;
        rem_nxt = rem_r;
        arr_nxt = arr_r;
        if (cmd_take) begin
            case (cmd_kind)
                `PROF_CMD_ARRAY: begin
                    state_nxt = ST_RUN;
                    arr_nxt = 1'b1;
                end
                `PROF_CMD_READ, `PROF_CMD_XCHG: begin
                    state_nxt = ST_CHECK;
                    arr_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    arr_nxt = 1'b0;
                end
            endcase
            rem_nxt = 9'h000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    rem_nxt = 9'h000;
                end
                ST_CHECK: begin
                    if (fits) begin
                        state_nxt = ST_RUN;
                        rem_nxt = group_len;
                    end else begin
                        state_nxt = ST_STALL;
                    end
                end
                ST_RUN: begin
                    if (push && !arr_r) begin
                        rem_nxt = rem_r - 9'h001;
                        if (rem_r == 9'h001) begin
                            state_nxt = ST_CHECK;
                        end
                    end
                end
                ST_STALL: begin
                    // Commands are not accepted here, so only draining or a lower req_r ends a stall.
                    if (resume) begin
                        state_nxt = ST_RUN;
                        rem_nxt = group_len;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    rem_nxt = 9'h000;
                    arr_nxt = 1'b0;
                end
            endcase
        end
    end

    // APB read multiplexer, evaluated in the setup cycle.
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `PROF_ADDR_REQ: rd_mux = {24'h000000, req_r};
            `PROF_ADDR_LIMIT: rd_mux = {25'h0, limit_r};
            `PROF_ADDR_STATUS: begin
                rd_mux[`PROF_CW-1:0] = count;
                rd_mux[`PROF_ST_STALL] = stalled_r;
                rd_mux[`PROF_ST_LEVEL] = level;
                rd_mux[`PROF_ST_ACTIVE] = (state_r != ST_IDLE);
            end
            `PROF_ADDR_DATA: rd_mux = fifo_rd_data;
            `PROF_ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
            `PROF_ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
            `PROF_ADDR_VARIANT: rd_mux = {24'h000000, `PROF_VARIANT_ID};
            default: rd_hit = 1'b0;
        endcase
    end

    // Flow state and handshake outputs.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            rem_r <= 9'h000;
            arr_r <= 1'b0;
            cmd_ready_r <= 1'b0;
            pix_ready_r <= 1'b0;
            stalled_r <= 1'b0;
            dma_req_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            rem_r <= rem_nxt;
            arr_r <= arr_nxt;
            cmd_ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_CHECK)
                           || ((state_nxt == ST_RUN) && arr_nxt);
            if (state_nxt != ST_RUN) begin
                pix_ready_r <= 1'b0;
            end else if (arr_nxt) begin
                pix_ready_r <= (occ_nxt < DEPTH_C);
            end else begin
                pix_ready_r <= (rem_nxt != 9'h000);
            end
            stalled_r <= (state_nxt == ST_STALL);
            dma_req_r <= level;
        end
    end

    // APB slave: no wait state, answer in the first access cycle after setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            req_r <= `PROF_REQ_RESET;
            limit_r <= `PROF_LIMIT_RESET;
            irq_mask_r <= `PROF_MASK_RESET;
        end else if (clk_en) begin
            pready_r <= apb_setup;
            if (apb_setup) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= ~rd_hit;
            end else if (apb_done) begin
                pslverr_r <= 1'b0;
            end
            if (wr_done) begin
                case (paddr)
                    `PROF_ADDR_REQ: req_r <= pwdata[7:0];
                    `PROF_ADDR_LIMIT: limit_r <= pwdata[`PROF_CW-1:0];
                    `PROF_ADDR_IRQ_MASK: irq_mask_r <= pwdata[2:0];
                    default: req_r <= req_r;
                endcase
            end
        end
    end

    // Sticky interrupt status: a new event wins over a write-one clear.
    wire [2:0] irq_event = {group_end, stall_enter, level};
    wire irq_clr_wr = wr_done & (paddr == `PROF_ADDR_IRQ_STAT);
    genvar gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat_r[gi] <= 1'b0;
                end else if (clk_en) begin
                    irq_stat_r[gi] <= irq_event[gi]
                                      | (irq_stat_r[gi] & ~(irq_clr_wr & pwdata[gi]));
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cmd_ready = cmd_ready_r;
    assign pix_ready = pix_ready_r;
    assign dma_req = dma_req_r;
    assign stalled = stalled_r;
    assign irq = irq_r;
endmodule // prof_flow
`default_nettype wire

// ---- core/prof_map.vh ----
// Register map, field positions and constants of the read-back output FIFO flow block.
`ifndef PROF_MAP_VH
`define PROF_MAP_VH

`define PROF_DEPTH 64
`define PROF_AW 6
`define PROF_CW 7

`define PROF_ADDR_REQ 8'h00
`define PROF_ADDR_LIMIT 8'h04
`define PROF_ADDR_STATUS 8'h08
`define PROF_ADDR_DATA 8'h0c
`define PROF_ADDR_IRQ_STAT 8'h10
`define PROF_ADDR_IRQ_MASK 8'h14
`define PROF_ADDR_VARIANT 8'h18

`define PROF_REQ_RESET 8'h00
`define PROF_LIMIT_RESET 7'h00
`define PROF_MASK_RESET 3'h0

`define PROF_ST_STALL 8
`define PROF_ST_LEVEL 9
`define PROF_ST_ACTIVE 10

`define PROF_IRQ_LEVEL 0
`define PROF_IRQ_STALL 1
`define PROF_IRQ_GROUP 2

`define PROF_CMD_OTHER 2'h0
`define PROF_CMD_READ 2'h1
`define PROF_CMD_XCHG 2'h2
`define PROF_CMD_ARRAY 2'h3

// Arbitrary neutral value for the device variant field.
`define PROF_VARIANT_ID 8'h5a

`endif

// ---- core/prof_out_fifo.v ----
// Output FIFO storage with occupancy count.
`timescale 1ns/1ps
`default_nettype none
`include "prof_map.vh"

module prof_out_fifo (
    // Clock, reset and enable.
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // Write side.
    input wire wr_en,
    input wire [31:0] wr_data,
    // Read side.
    input wire rd_en,
    output wire [31:0] rd_data,
    output wire [`PROF_CW-1:0] count
);
    reg [31:0] mem_r [0:`PROF_DEPTH-1];
    reg [`PROF_AW-1:0] wptr_r;
    reg [`PROF_AW-1:0] rptr_r;
    reg [`PROF_CW-1:0] count_r;

    assign rd_data = mem_r[rptr_r];
    assign count = count_r;

    always @(posedge pclk) begin
        if (clk_en && wr_en) begin
            mem_r[wptr_r] <= wr_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= {`PROF_AW{1'b0}};
            rptr_r <= {`PROF_AW{1'b0}};
            count_r <= {`PROF_CW{1'b0}};
        end else if (clk_en) begin
            if (wr_en) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (rd_en) begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (wr_en && !rd_en) begin
                count_r <= count_r + 1'b1;
            end else if (rd_en && !wr_en) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // prof_out_fifo
`default_nettype wire

// ---- tb/prof_pix_src.sv ----
// Pixel processor model that offers consecutively numbered words.
`timescale 1ns/1ps
`default_nettype none
module prof_pix_src (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Word offer.
    input wire logic pix_ready,
    output logic pix_valid,
    output logic [31:0] pix_data
);
    assign pix_valid = presetn;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_data <= 32'h0;
        end else if (pix_ready) begin
            pix_data <= pix_data + 32'h1;
        end
    end
endmodule // prof_pix_src
`default_nettype wire

// ---- tb/prof_flow_checker.sv ----
// Concurrent checks on the ports of the read-back flow block.
`timescale 1ns/1ps
`default_nettype none
module prof_flow_checker (
    // Clock and control.
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // Register bus.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Command and pixel path.
    input wire cmd_valid,
    input wire [1:0] cmd_kind,
    input wire cmd_ready,
    input wire pix_ready,
    input wire stalled
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_grp;
        cmd_valid && cmd_ready && (cmd_kind == 2'h1 || cmd_kind == 2'h2);
    endsequence
    AST_PREADY_ANSWER: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("answer held too long");
    AST_SLVERR_RANGE: assert property (s_setup ##0 paddr > 8'h18 |=> pslverr)
        else $error("unmapped address accepted");
    AST_RD_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    AST_STALL_NO_CMD: assert property (stalled |-> !cmd_ready)
        else $error("command offered while stalled");
    AST_STALL_NO_PIX: assert property (stalled |-> !pix_ready)
        else $error("pixel path open while stalled");
    AST_STALL_HOLD: assert property ((!(psel && penable))[*4] ##0 stalled |=> stalled)
        else $error("stall left without draining");
    AST_GROUP_START: assert property (s_grp |-> ##[2:3] (pix_ready || stalled))
        else $error("group neither started nor stalled");
endmodule // prof_flow_checker
bind prof_flow prof_flow_checker u_prof_flow_checker (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .pix_ready(pix_ready), .stalled(stalled));
`default_nettype wire

// ---- tb/prof_flow_test.sv ----
// Testbench of the read-back flow block driven over its register bus and its command port.
`timescale 1ns/1ps
`default_nettype none
`include "prof_map.vh"
module prof_flow_test;
    logic pclk, presetn, psel, penable, pwrite, cmd_valid, pix_valid;
    logic [1:0] cmd_kind;
    logic [7:0] paddr;
    logic [31:0] pwdata, pix_data, prdata, rdat;
    wire pready, pslverr, cmd_ready, pix_ready, dma_req, stalled, irq;
    logic rerr;
    int n_mismatch, num_checks, cyc, e;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h5a, 32'h0};
    prof_flow u_prof_flow (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_ready(cmd_ready), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .dma_req(dma_req), .stalled(stalled), .irq(irq));
    prof_pix_src u_prof_pix_src (.pclk(pclk), .presetn(presetn), .pix_ready(pix_ready),
        .pix_valid(pix_valid), .pix_data(pix_data));
    always #2 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pop();
        apb(1'b0, `PROF_ADDR_DATA, 32'h0);
        chk("data", rdat, e);
        e++;
    endtask
    task automatic drain();
        apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        while (rdat[6:0] !== 7'h0) begin
            pop();
            apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        end
    endtask
    task automatic cmd(input logic [1:0] k);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        do @(posedge pclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, cmd_valid, cmd_kind, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset_value", rdat, rv[i]);
            chk("reset_err", {31'h0, rerr}, {31'h0, i == 4});
        end
        apb(1'b1, `PROF_ADDR_REQ, 32'h4);
        apb(1'b1, `PROF_ADDR_LIMIT, 32'h3c);
        apb(1'b1, `PROF_ADDR_IRQ_MASK, 32'h2);
        cmd(`PROF_CMD_READ);
        while (stalled !== 1'b1) @(posedge pclk);
        apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        chk("status_full", rdat, 32'h73c);
        chk("dma_req", {31'h0, dma_req}, 32'h1);
        chk("irq_stall", {31'h0, irq}, 32'h1);
        apb(1'b0, `PROF_ADDR_IRQ_STAT, 32'h0);
        chk("irq_stat", rdat, 32'h7);
        cmd_valid <= 1'b1;
        cmd_kind <= `PROF_CMD_OTHER;
        repeat (4) @(posedge pclk);
        chk("stall_cmd", {31'h0, stalled}, 32'h1);
        cmd_valid <= 1'b0;
        pop();
        repeat (3) @(posedge pclk);
        chk("stall_59", {31'h0, stalled}, 32'h1);
        pop();
        repeat (4) @(posedge pclk);
        chk("resume_58", {31'h0, stalled}, 32'h0);
        while (stalled !== 1'b1) @(posedge pclk);
        apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        chk("status_63", rdat, 32'h73f);
        apb(1'b1, `PROF_ADDR_IRQ_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq_clear", {31'h0, irq}, 32'h0);
        cmd_valid <= 1'b1;
        repeat (40) pop();
        cmd_valid <= 1'b0;
        drain();
        apb(1'b1, `PROF_ADDR_LIMIT, 32'h28);
        cmd(`PROF_CMD_XCHG);
        while (dma_req !== 1'b1) @(posedge pclk);
        apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        chk("small_pkg", {22'h0, rdat[9:8], 8'h0}, 32'h200);
        cmd(`PROF_CMD_OTHER);
        drain();
        cmd(`PROF_CMD_ARRAY);
        repeat (80) @(posedge pclk);
        apb(1'b0, `PROF_ADDR_STATUS, 32'h0);
        chk("array_full", rdat, 32'h640);
        chk("array_ready", {31'h0, pix_ready}, 32'h0);
        cmd(`PROF_CMD_OTHER);
        test_done();
    end
endmodule // prof_flow_test
`default_nettype wire
